// >>> bench/tb_top.sv
`default_nettype none
module tb_top
  import tcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned PER  = 200;
  localparam int unsigned STBY = 3;

  logic                    mclk, resetn, copy_all, copy_one, slow;
  logic                    adc_done, math_start, math_done, obj_valid;
  logic                    standby, copy_busy, otp_rd, otp_valid, cur_tp;
  logic [2:0]              sel, copy_idx, grp_sel, prev_sel;
  logic [4:0]              lat;
  logic signed [ADC_W-1:0] die_v, tp_v, adc_data;
  logic signed [RES_W-1:0] obj_v, math_res, exp_obj, held_die, held_tp;
  logic [RES_W-1:0]        otp_base, otp_data;
  logic [COEF_IDX_W-1:0]   otp_addr;
  logic [COEF_N-1:0][RES_W-1:0] coef;
  logic [RES_W-1:0]        cexp [COEF_N];
  logic signed [ACC_W-1:0] die_sum, tp_sum;
  tcs_adc_req_t            adc_req;
  tcs_results_t            res;
  int                      mismatches, cmp_count, cyc, last_die, ngrp;
  int                      grp_done;
  logic                    pend_res, pend_obj, stby_seen, started;

  tcs_sequencer #(.PERIOD_CYC(PER), .STBY_SLOTS(STBY)) dut (
    .mclk_in(mclk), .resetn_in(resetn), .averaging_select_in(sel),
    .adc_req_out(adc_req), .adc_done_in(adc_done), .adc_data_in(adc_data),
    .math_start_out(math_start), .math_done_in(math_done),
    .math_result_in(math_res), .results_out(res), .obj_valid_out(obj_valid),
    .standby_out(standby), .copy_all_in(copy_all), .copy_one_in(copy_one),
    .copy_idx_in(copy_idx), .copy_busy_out(copy_busy), .otp_rd_out(otp_rd),
    .otp_addr_out(otp_addr), .otp_valid_in(otp_valid),
    .otp_data_in(otp_data), .coef_out(coef));

  tcs_far_model far (
    .mclk_in(mclk), .resetn_in(resetn), .lat_in(lat), .die_in(die_v),
    .tp_in(tp_v), .obj_in(obj_v), .base_in(otp_base), .adc_req_in(adc_req),
    .adc_done_out(adc_done), .adc_data_out(adc_data),
    .math_start_in(math_start), .math_done_out(math_done),
    .math_res_out(math_res), .otp_rd_in(otp_rd), .otp_addr_in(otp_addr),
    .otp_valid_out(otp_valid), .otp_data_out(otp_data));

  always #5 mclk = ~mclk;

  task automatic chk_word(input logic [RES_W-1:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_count(input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Averaging depth per code; low-power codes reuse the low depths.
  function automatic int shift_of(input logic [2:0] c);
    return (c >= 3'h5) ? int'(c) - 5 : int'(c);
  endfunction

  // Mean of a group sum, clipped to the 16-bit result range.
  function automatic logic [RES_W-1:0] exp_mean(
      input logic signed [ACC_W-1:0] sum, input int sh);
    logic signed [ACC_W-1:0] m;
    m = sum >>> sh;
    if (m > ACC_W'(RES_POS_FULL)) return RES_POS_FULL;
    if (m < ACC_W'(RES_NEG_FULL)) return RES_NEG_FULL;
    return m[RES_W-1:0];
  endfunction

  task automatic chk_coefs();
    for (int i = 0; i < COEF_N; i++) chk_word(coef[i], cexp[i]);
  endtask

  // Bounded wait for k more finished groups; the select may then change,
  // since the next group start is still most of a slot away.
  task automatic wait_groups(input int k);
    int g0;
    g0 = grp_done;
    for (int i = 0; i < 20000 && grp_done < g0 + k; i++) @(negedge mclk);
    // A group that never finishes is a failure, not a silent skip.
    if (grp_done < g0 + k) mismatches++;
  endtask

  task automatic do_copy(input logic all, input logic [2:0] idx);
    @(negedge mclk);
    otp_base = otp_base + 16'h1111;
    {copy_all, copy_one, copy_idx} = {all, !all, idx};
    @(negedge mclk);
    {copy_all, copy_one} = 2'h0;
    repeat (3) @(negedge mclk);
    for (int i = 0; i < 20000 && copy_busy !== 1'h0; i++) @(negedge mclk);
    if (copy_busy !== 1'h0) mismatches++;
    for (int i = 0; i < COEF_N; i++)
      if (all || i == int'(idx)) cexp[i] = otp_base + 16'(i) * 16'h0101;
  endtask

  // Follows each group on the converter handshake and checks results.
  always @(posedge mclk) begin
    cyc++;
    if (!resetn) begin
      {ngrp, pend_res, pend_obj, started} = '0;
    end else begin
      if (pend_res || math_start) begin
        chk_count(32'(math_start), 32'(pend_res));
        held_die = exp_mean(die_sum, shift_of(grp_sel));
        held_tp = exp_mean(tp_sum, shift_of(grp_sel));
        chk_word(res.die, held_die);
        chk_word(res.tp, held_tp);
        pend_res = 0;
      end
      if (pend_obj || obj_valid) begin
        chk_count(32'(obj_valid), 32'(pend_obj));
        chk_word(res.obj, exp_obj);
        pend_obj = 0;
        grp_done++;
      end
      if (math_done) {pend_obj, exp_obj} = {1'h1, math_res};
      if (standby) stby_seen = 1;
      if (adc_done && cur_tp) begin
        chk_word(res.tp, held_tp);
        tp_sum += ACC_W'(adc_data);
        ngrp++;
        if (ngrp == (1 << shift_of(grp_sel))) {pend_res, ngrp} = {1'h1, 0};
      end else if (adc_done) begin
        chk_word(res.die, held_die);
        die_sum += ACC_W'(adc_data);
      end
      if (adc_req.start) cur_tp = adc_req.sel;
      if (adc_req.start && !adc_req.sel) begin
        if (ngrp != 0) begin
          chk_count(32'(cyc - last_die), PER);
        end else begin
          prev_sel = grp_sel;
          if (started) begin
            chk_count(32'(stby_seen), 32'(prev_sel >= 3'h5));
          end
          {grp_sel, die_sum, tp_sum, stby_seen, started} =
            {sel, {ACC_W{1'h0}}, {ACC_W{1'h0}}, 1'h0, 1'h1};
        end
        last_die = cyc;
      end
    end
  end

  // Random samples, engine results and answer latency, one set a cycle.
  initial begin
    logic [31:0] r;
    r = $urandom(86);
    {die_v, tp_v, obj_v, lat} = '0;
    forever begin
      @(negedge mclk);
      r = $urandom;
      die_v = r[31] ? ADC_W'($signed(r[15:0])) : r[19:0];
      lat = slow ? r[28:24] : 5'h0;
      r = $urandom;
      tp_v = r[31] ? ADC_W'($signed(r[15:0])) : r[19:0];
      obj_v = r[27:12];
    end
  end

  initial begin
    repeat (90000) @(posedge mclk);
    mismatches++;
    test_done();
  end

  initial begin
    {mclk, resetn, copy_all, copy_one, slow, cyc, grp_done} = '0;
    {mismatches, cmp_count, held_die, held_tp, copy_idx} = '0;
    {sel, otp_base, grp_sel, cur_tp} = {3'h2, 16'h3c5a, 3'h2, 1'h0};
    repeat (16) @(posedge mclk);
    @(negedge mclk);
    resetn = 1;
    repeat (3) @(negedge mclk);
    for (int i = 0; i < 20000 && copy_busy !== 1'h0; i++) @(negedge mclk);
    if (copy_busy !== 1'h0) mismatches++;
    for (int i = 0; i < COEF_N; i++) cexp[i] = otp_base + 16'(i) * 16'h0101;
    chk_coefs();
    wait_groups(1);
    for (int c = 0; c < 8; c++) begin
      {sel, slow} = {3'(c), c[0]};
      wait_groups(2);
    end
    // Change the select well inside a long group: that group must keep
    // its old depth, and only the following group may take the new code.
    sel = 3'h3;
    wait_groups(1);
    repeat (300) @(negedge mclk);
    sel = 3'h0;
    wait_groups(2);
    do_copy(1'h0, 3'h5);
    chk_coefs();
    do_copy(1'h1, 3'h0);
    chk_coefs();
    test_done();
  end
endmodule
`default_nettype wire

// >>> bench/tcs_far_model.sv
`default_nettype none
module tcs_far_model
  import tcs_pkg::*;
(
  // Clock and reset.
  input  wire logic                    mclk_in,
  input  wire logic                    resetn_in,
  // Values and latency offered by the bench.
  input  wire logic [4:0]              lat_in,
  input  wire logic signed [ADC_W-1:0] die_in,
  input  wire logic signed [ADC_W-1:0] tp_in,
  input  wire logic signed [RES_W-1:0] obj_in,
  input  wire logic [RES_W-1:0]        base_in,
  // Converter, engine and one-time memory.
  input  wire tcs_adc_req_t            adc_req_in,
  output logic                         adc_done_out,
  output logic signed [ADC_W-1:0]      adc_data_out,
  input  wire logic                    math_start_in,
  output logic                         math_done_out,
  output logic signed [RES_W-1:0]      math_res_out,
  input  wire logic                    otp_rd_in,
  input  wire logic [COEF_IDX_W-1:0]   otp_addr_in,
  output logic                         otp_valid_out,
  output logic [RES_W-1:0]             otp_data_out
);
  int unsigned             a_cnt, m_cnt, o_cnt;
  logic signed [ADC_W-1:0] a_hold;
  logic signed [RES_W-1:0] m_hold;
  logic [RES_W-1:0]        o_hold;

  // Each unit answers lat_in+2 cycles after its request. Idle data lines
  // toggle every cycle, so a stale value can never pass for a fresh one.
  always @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      {a_cnt, m_cnt, o_cnt} <= '0;
      {adc_done_out, math_done_out, otp_valid_out} <= '0;
      {adc_data_out, math_res_out, otp_data_out} <= '0;
    end else begin
      {adc_done_out, math_done_out, otp_valid_out} <= '0;
      adc_data_out <= ~adc_data_out;
      math_res_out <= ~math_res_out;
      otp_data_out <= ~otp_data_out;
      if (adc_req_in.start) begin
        a_cnt  <= 32'(lat_in) + 1;
        a_hold <= adc_req_in.sel ? tp_in : die_in;
      end else if (a_cnt != 0) begin
        a_cnt <= a_cnt - 1;
        if (a_cnt == 1) begin
          adc_done_out <= 1'h1;
          adc_data_out <= a_hold;
        end
      end
      if (math_start_in) begin
        m_cnt  <= 32'(lat_in) + 1;
        m_hold <= obj_in;
      end else if (m_cnt != 0) begin
        m_cnt <= m_cnt - 1;
        if (m_cnt == 1) begin
          math_done_out <= 1'h1;
          math_res_out  <= m_hold;
        end
      end
      if (otp_rd_in) begin
        o_cnt  <= 32'(lat_in) + 1;
        o_hold <= base_in + RES_W'(otp_addr_in) * 16'h0101;
      end else if (o_cnt != 0) begin
        o_cnt <= o_cnt - 1;
        if (o_cnt == 1) begin
          otp_valid_out <= 1'h1;
          otp_data_out  <= o_hold;
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> inc/tcs_pkg.sv
`default_nettype none
package tcs_pkg;
  // Clock rate and conversion slot timing.
  localparam int unsigned CLK_FREQ_KHZ    = 100_000;
  localparam int unsigned BASE_PERIOD_MS  = 250;
  localparam int unsigned BASE_PERIOD_CYC = BASE_PERIOD_MS * CLK_FREQ_KHZ;
  localparam int unsigned STANDBY_SLOTS   = 3;

  // Data path widths.
  localparam int unsigned RES_W      = 16;
  localparam int unsigned ADC_W      = 20;
  localparam int unsigned MAX_SHIFT  = 4;
  localparam int unsigned ACC_W      = ADC_W + MAX_SHIFT;
  localparam int unsigned COEF_N     = 8;
  localparam int unsigned COEF_IDX_W = 3;

  // Mode codes, reset values and saturation codes.
  localparam logic [2:0]              AVG_SEL_RESET  = 3'h2;
  localparam logic [2:0]              AVG_SEL_LOWPWR = 3'h5;
  localparam logic signed [RES_W-1:0] RES_POS_FULL   = 16'h7FFF;
  localparam logic signed [RES_W-1:0] RES_NEG_FULL   = 16'h8000;
  localparam logic                    ADC_SEL_DIE    = 1'b0;
  localparam logic                    ADC_SEL_TP     = 1'b1;

  typedef enum logic [3:0] {
    TCS_ST_GROUP   = 4'h0,
    TCS_ST_COPY_RD = 4'h1,
    TCS_ST_COPY_WT = 4'h2,
    TCS_ST_DIE     = 4'h3,
    TCS_ST_TP      = 4'h4,
    TCS_ST_MATH    = 4'h5,
    TCS_ST_SLOT    = 4'h6,
    TCS_ST_STANDBY = 4'h7
  } tcs_state_t;

  typedef struct packed {
    logic start;
    logic sel;
  } tcs_adc_req_t;

  typedef struct packed {
    logic signed [RES_W-1:0] die;
    logic signed [RES_W-1:0] tp;
    logic signed [RES_W-1:0] obj;
  } tcs_results_t;

  // Power-of-two averaging depth for a select code.
  function automatic logic [2:0] tcs_avg_shift(input logic [2:0] sel);
    if (sel >= AVG_SEL_LOWPWR) begin
      return 3'(sel - AVG_SEL_LOWPWR);
    end
    return sel;
  endfunction

  // Codes that insert a standby interval after each group.
  function automatic logic tcs_is_lowpwr(input logic [2:0] sel);
    return sel >= AVG_SEL_LOWPWR;
  endfunction
endpackage
`default_nettype wire

// >>> rtl/tcs_avg_acc.sv
`default_nettype none
module tcs_avg_acc
  import tcs_pkg::*;
(
  // Clock and reset.
  input  wire logic                    mclk_in,
  input  wire logic                    resetn_in,
  // Sample stream.
  input  wire logic                    clear_in,
  input  wire logic                    add_in,
  input  wire logic                    last_in,
  input  wire logic [2:0]              shift_in,
  input  wire logic signed [ADC_W-1:0] sample_in,
  // Averaged result.
  output logic signed [RES_W-1:0]      mean_out,
  output logic                         load_out
);
  typedef struct packed {
    logic signed [ACC_W-1:0] acc;
    logic signed [RES_W-1:0] res;
    logic                    upd;
  } tcs_acc_st_t;

  tcs_acc_st_t             q_ff;
  tcs_acc_st_t             nxt_q;
  logic signed [ACC_W-1:0] sum;
  logic signed [ACC_W-1:0] mean;

  // Running sum; the result only moves on the last sample of a group.
  always_comb begin
    nxt_q     = q_ff;
    nxt_q.upd = 1'b0;
    sum       = q_ff.acc + ACC_W'(sample_in);
    mean      = sum >>> shift_in;
    if (clear_in) begin
      nxt_q.acc = '0;
    end else if (add_in && last_in) begin
      nxt_q.acc = '0;
      nxt_q.upd = 1'b1;
      // The head room of the sum keeps the mean exact before clipping.
      if (mean > ACC_W'(RES_POS_FULL)) begin
        nxt_q.res = RES_POS_FULL;
      end else if (mean < ACC_W'(RES_NEG_FULL)) begin
        nxt_q.res = RES_NEG_FULL;
      end else begin
        nxt_q.res = mean[RES_W-1:0];
      end
    end else if (add_in) begin
      nxt_q.acc = sum;
    end
  end

  // State register.
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign mean_out = q_ff.res;
  assign load_out = q_ff.upd;

  // Positive overrange on the last sample clips to the positive full-scale code.
  property p_sat_pos;
    @(posedge mclk_in) disable iff (!resetn_in)
    (add_in && last_in && !clear_in && mean > ACC_W'(RES_POS_FULL))
      |=> (mean_out == RES_POS_FULL);
  endproperty
  a_sat_pos: assert property (p_sat_pos)
    else $error("positive overrange not clipped");

  // Negative overrange clips to the negative full-scale code.
  property p_sat_neg;
    @(posedge mclk_in) disable iff (!resetn_in)
    (add_in && last_in && !clear_in && mean < ACC_W'(RES_NEG_FULL))
      |=> (mean_out == RES_NEG_FULL);
  endproperty
  a_sat_neg: assert property (p_sat_neg)
    else $error("negative overrange not clipped");
endmodule
`default_nettype wire

// >>> rtl/tcs_sequencer.sv
`default_nettype none
module tcs_sequencer
  import tcs_pkg::*;
#(
  parameter int unsigned PERIOD_CYC = BASE_PERIOD_CYC,
  parameter int unsigned STBY_SLOTS = STANDBY_SLOTS
) (
  // Clock and reset.
  input  wire logic                         mclk_in,
  input  wire logic                         resetn_in,
  // Mode selection.
  input  wire logic [2:0]                   averaging_select_in,
  // Converter handshake.
  output tcs_adc_req_t                      adc_req_out,
  input  wire logic                         adc_done_in,
  input  wire logic signed [ADC_W-1:0]      adc_data_in,
  // Arithmetic engine handshake.
  output logic                              math_start_out,
  input  wire logic                         math_done_in,
  input  wire logic signed [RES_W-1:0]      math_result_in,
  // Results.
  output tcs_results_t                      results_out,
  output logic                              obj_valid_out,
  output logic                              standby_out,
  // Coefficient copy from one-time memory.
  input  wire logic                         copy_all_in,
  input  wire logic                         copy_one_in,
  input  wire logic [COEF_IDX_W-1:0]        copy_idx_in,
  output logic                              copy_busy_out,
  output logic                              otp_rd_out,
  output logic [COEF_IDX_W-1:0]             otp_addr_out,
  input  wire logic                         otp_valid_in,
  input  wire logic [RES_W-1:0]             otp_data_in,
  output logic [COEF_N-1:0][RES_W-1:0]      coef_out
);
  localparam logic [31:0] SLOT_LAST = 32'(PERIOD_CYC - 1);
  localparam logic [7:0]  STBY_LAST = 8'(STBY_SLOTS - 1);

  typedef struct packed {
    tcs_state_t                     st;
    logic [2:0]                     mode;
    logic [4:0]                     cnt;
    logic [31:0]                    tmr;
    logic [7:0]                     sb;
    logic                           pend_all;
    logic                           pend_one;
    logic [COEF_IDX_W-1:0]          pend_idx;
    logic [COEF_IDX_W-1:0]          idx;
    logic [COEF_IDX_W-1:0]          last_idx;
    logic                           otp_rd;
    tcs_adc_req_t                   adc;
    logic                           math_start;
    logic signed [RES_W-1:0]        obj;
    logic                           obj_valid;
    logic [COEF_N-1:0][RES_W-1:0]   coef;
  } tcs_seq_st_t;

  tcs_seq_st_t       q_ff;
  tcs_seq_st_t       nxt_q;
  logic [2:0]        shift;
  logic [4:0]        n_last;
  logic              slot_end;
  logic              grp_last;
  logic              group_go;
  logic              die_add;
  logic              tp_add;
  logic              die_load;
  logic              tp_load;
  // Each averager drives its own net; one assignment builds the bundle.
  logic [RES_W-1:0]  die_mean;
  logic [RES_W-1:0]  tp_mean;

  // Decoded group size from the mode latched for the running group.
  assign shift    = tcs_avg_shift(q_ff.mode);
  assign n_last   = 5'((5'h01 << shift) - 5'h01);
  assign grp_last = (q_ff.cnt == n_last);
  assign slot_end = (q_ff.tmr >= SLOT_LAST);
  assign die_add  = (q_ff.st == TCS_ST_DIE) && adc_done_in;
  assign tp_add   = (q_ff.st == TCS_ST_TP) && adc_done_in;
  assign group_go = (q_ff.st == TCS_ST_GROUP) && !q_ff.pend_all
                    && !q_ff.pend_one;

  // Die and thermopile averagers share one structure.
  tcs_avg_acc u_die_avg (
    .mclk_in   (mclk_in),
    .resetn_in (resetn_in),
    .clear_in  (group_go),
    .add_in    (die_add),
    .last_in   (grp_last),
    .shift_in  (shift),
    .sample_in (adc_data_in),
    .mean_out  (die_mean),
    .load_out  (die_load)
  );

  tcs_avg_acc u_tp_avg (
    .mclk_in   (mclk_in),
    .resetn_in (resetn_in),
    .clear_in  (group_go),
    .add_in    (tp_add),
    .last_in   (grp_last),
    .shift_in  (shift),
    .sample_in (adc_data_in),
    .mean_out  (tp_mean),
    .load_out  (tp_load)
  );

  // Sequencer: groups of slots, coefficient copies between groups.
  always_comb begin
    nxt_q            = q_ff;
    nxt_q.tmr        = q_ff.tmr + 32'h0000_0001;
    nxt_q.otp_rd     = 1'b0;
    nxt_q.adc.start  = 1'b0;
    nxt_q.math_start = 1'b0;
    nxt_q.obj_valid  = 1'b0;
    // A request in the cycle its flag is taken is kept, not lost.
    if (copy_all_in) begin
      nxt_q.pend_all = 1'b1;
    end
    if (copy_one_in) begin
      nxt_q.pend_one = 1'b1;
      nxt_q.pend_idx = copy_idx_in;
    end
    case (q_ff.st)
      TCS_ST_GROUP: begin
        // Copies wait for a group boundary so results stay coherent.
        if (q_ff.pend_all) begin
          nxt_q.pend_all = copy_all_in;
          nxt_q.idx      = '0;
          nxt_q.last_idx = COEF_IDX_W'(COEF_N - 1);
          nxt_q.st       = TCS_ST_COPY_RD;
        end else if (q_ff.pend_one) begin
          nxt_q.pend_one = copy_one_in;
          nxt_q.idx      = q_ff.pend_idx;
          nxt_q.last_idx = q_ff.pend_idx;
          nxt_q.st       = TCS_ST_COPY_RD;
        end else begin
          nxt_q.mode      = averaging_select_in;
          nxt_q.cnt       = '0;
          nxt_q.tmr       = '0;
          nxt_q.adc.start = 1'b1;
          nxt_q.adc.sel   = ADC_SEL_DIE;
          nxt_q.st        = TCS_ST_DIE;
        end
      end
      TCS_ST_COPY_RD: begin
        nxt_q.otp_rd = 1'b1;
        nxt_q.st     = TCS_ST_COPY_WT;
      end
      TCS_ST_COPY_WT: begin
        if (otp_valid_in) begin
          nxt_q.coef[q_ff.idx] = otp_data_in;
          nxt_q.idx            = q_ff.idx + COEF_IDX_W'(1);
          nxt_q.st = (q_ff.idx == q_ff.last_idx) ? TCS_ST_GROUP
                                                 : TCS_ST_COPY_RD;
        end
      end
      TCS_ST_DIE: begin
        if (adc_done_in) begin
          nxt_q.adc.start = 1'b1;
          nxt_q.adc.sel   = ADC_SEL_TP;
          nxt_q.st        = TCS_ST_TP;
        end
      end
      TCS_ST_TP: begin
        if (adc_done_in) begin
          nxt_q.cnt = q_ff.cnt + 5'h01;
          // Operands are the registered averages, valid one edge later.
          nxt_q.math_start = grp_last;
          nxt_q.st = grp_last ? TCS_ST_MATH : TCS_ST_SLOT;
        end
      end
      TCS_ST_MATH: begin
        if (math_done_in) begin
          nxt_q.obj       = math_result_in;
          nxt_q.obj_valid = 1'b1;
          nxt_q.st        = TCS_ST_SLOT;
        end
      end
      TCS_ST_SLOT: begin
        // A slot always lasts one full period, even if work ends early.
        if (slot_end) begin
          nxt_q.tmr = '0;
          nxt_q.sb  = '0;
          if (q_ff.cnt != 5'(n_last + 5'h01)) begin
            nxt_q.adc.start = 1'b1;
            nxt_q.adc.sel   = ADC_SEL_DIE;
            nxt_q.st        = TCS_ST_DIE;
          end else if (tcs_is_lowpwr(q_ff.mode)) begin
            nxt_q.st = TCS_ST_STANDBY;
          end else begin
            nxt_q.st = TCS_ST_GROUP;
          end
        end
      end
      TCS_ST_STANDBY: begin
        if (slot_end) begin
          nxt_q.tmr = '0;
          nxt_q.sb  = q_ff.sb + 8'h01;
          if (q_ff.sb >= STBY_LAST) begin
            nxt_q.st = TCS_ST_GROUP;
          end
        end
      end
      default: begin
        nxt_q.st = TCS_ST_GROUP;
      end
    endcase
  end

  // State register; reset queues a full coefficient load.
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      q_ff          <= '0;
      q_ff.st       <= TCS_ST_GROUP;
      q_ff.mode     <= AVG_SEL_RESET;
      q_ff.pend_all <= 1'b1;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // Outputs come from the state register; the die and tp results come from the averagers' registers.
  assign adc_req_out     = q_ff.adc;
  assign math_start_out  = q_ff.math_start;
  assign results_out     = {die_mean, tp_mean, q_ff.obj};
  assign obj_valid_out   = q_ff.obj_valid;
  assign standby_out     = (q_ff.st == TCS_ST_STANDBY);
  assign copy_busy_out   = (q_ff.st == TCS_ST_COPY_RD)
                           || (q_ff.st == TCS_ST_COPY_WT)
                           || q_ff.pend_all || q_ff.pend_one;
  assign otp_rd_out      = q_ff.otp_rd;
  assign otp_addr_out    = q_ff.idx;
  assign coef_out        = q_ff.coef;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);

  // The mode is latched only at a group start.
  property p_mode_hold;
    !group_go |=> $stable(q_ff.mode);
  endproperty
  a_mode_hold: assert property (p_mode_hold)
    else $error("mode changed inside a group");

  property p_mode_take;
    group_go |=> (q_ff.mode == $past(averaging_select_in));
  endproperty
  a_mode_take: assert property (p_mode_take)
    else $error("mode not taken at group start");

  // The die result moves only on the last die sample of a group.
  property p_die_upd;
    !$stable(results_out.die) |-> $past(die_add && grp_last);
  endproperty
  a_die_upd: assert property (p_die_upd)
    else $error("die result moved off the last sample");

  property p_tp_upd;
    tp_load |-> $past(tp_add && grp_last) && math_start_out;
  endproperty
  a_tp_upd: assert property (p_tp_upd)
    else $error("thermopile load not followed by engine start");

  // The engine result lands exactly one edge after its done.
  property p_obj;
    (q_ff.st == TCS_ST_MATH && math_done_in)
      |=> obj_valid_out && results_out.obj == $past(math_result_in);
  endproperty
  a_obj: assert property (p_obj)
    else $error("object result not stored");

  property p_standby;
    standby_out |-> tcs_is_lowpwr(q_ff.mode);
  endproperty
  a_standby: assert property (p_standby)
    else $error("standby in a continuous mode");

  property p_copy;
    (q_ff.st == TCS_ST_COPY_WT && otp_valid_in)
      |=> coef_out[$past(q_ff.idx)] == $past(otp_data_in);
  endproperty
  a_copy: assert property (p_copy)
    else $error("coefficient not copied");

  // A new slot starts a die conversion on the edge after the period.
  property p_slot;
    (q_ff.st == TCS_ST_SLOT && slot_end && q_ff.cnt <= n_last)
      |=> adc_req_out.start && adc_req_out.sel == ADC_SEL_DIE;
  endproperty
  a_slot: assert property (p_slot)
    else $error("slot did not start a conversion");
endmodule
`default_nettype wire
